// ---- src/dpdl_top.sv ----
// Decision logic of the transformer differential protection function
// Summary of operation
// - A true user disable input forces every start output low.
// - Measurements keep flowing to the outputs while the function is disabled.
// - Each phase restrained start is its characteristic flag gated by not disabled.
// - The general restrained start is the OR of phase restrained flags gated by not disabled.
// - Each phase unrestrained start is its high-current flag gated by not disabled.
// - The general unrestrained start is the OR of phase high-current flags gated by not disabled.
// - A combined second harmonic restraint output is the OR of the phase second harmonic restraint outputs.
// - A combined fifth harmonic restraint output is the OR of the phase fifth harmonic flags.
// - Both general starts are presented as outputs for the fast trip logic.
// - Signs of an external fault switch the evaluator to a less sensitive characteristic.
// - Less sensitive mode starts after bias above 1.25 In with small differential for 3 ms.
// - Less sensitive mode ends when bias falls below 0.8 In.
// - In less sensitive mode the slopes are 50 % and 200 %.
// - Second harmonic restraint is allowed only with an angle difference of at least 75 degrees.
// - Each phase has its own second harmonic restraint output.
`timescale 1ns/100ps
`default_nettype none
module dpdl_top #(
    parameter int unsigned QUAL_CYCLES = dpdl_pkg::SAT_QUAL_CYCLES
) (
    // Clock, reset, enable
    input  wire logic                                          core_clk_i,
    input  wire logic                                          rst_i,
    input  wire logic                                          ce_i,
    // Sample strobe and function control
    input  wire logic                                          sample_i,
    input  wire logic                                          func_enable_i,
    input  wire logic                                          user_disable_input_i,
    // Evaluator flags and measurements
    input  var  dpdl_pkg::dpdl_flags_t                         flags_i,
    input  wire logic [dpdl_pkg::NUM_PHASES*dpdl_pkg::MAG_W-1:0] bias_i,
    input  wire logic [dpdl_pkg::NUM_PHASES*dpdl_pkg::MAG_W-1:0] diff_i,
    input  wire logic [dpdl_pkg::NUM_PHASES-1:0]               diff_below_base_i,
    input  wire logic [dpdl_pkg::ANG_W-1:0]                    angle_diff_i,
    // Starts
    output logic [dpdl_pkg::NUM_PHASES-1:0]                    restrained_start_o,
    output logic                                               restrained_start_any_o,
    output logic [dpdl_pkg::NUM_PHASES-1:0]                    unrestrained_start_o,
    output logic                                               unrestrained_start_any_o,
    // Restraints
    output logic [dpdl_pkg::NUM_PHASES-1:0]                    harm2_restraint_o,
    output logic                                               harm2_restraint_any_o,
    output logic                                               fifth_harmonic_restraint_o,
    // Characteristic selection and measurements
    output logic                                               desens_o,
    output var  dpdl_pkg::dpdl_slopes_t                        slopes_o,
    output logic [dpdl_pkg::NUM_PHASES*dpdl_pkg::MAG_W-1:0]    diff_meas_o,
    output logic [dpdl_pkg::NUM_PHASES*dpdl_pkg::MAG_W-1:0]    bias_meas_o
);
    logic                          desens_w;
    logic                          block_w;
    logic                          harm2_ok_w;
    logic [dpdl_pkg::NUM_PHASES-1:0] rs_next;
    logic [dpdl_pkg::NUM_PHASES-1:0] us_next;
    logic [dpdl_pkg::NUM_PHASES-1:0] h2_next;

    // Clears a per-phase start vector while the function is blocked; shared by both start kinds
    function automatic logic [dpdl_pkg::NUM_PHASES-1:0] gate_starts(
        input logic [dpdl_pkg::NUM_PHASES-1:0] raw,
        input logic                            blk
    );
        return blk ? '0 : raw;
    endfunction

    // Blocked when disabled by the user or the function is off
    assign block_w    = user_disable_input_i || !func_enable_i;
    assign harm2_ok_w = angle_diff_i >= dpdl_pkg::ANGLE_MIN_DEG;
    assign rs_next    = gate_starts(flags_i.restr, block_w);
    assign us_next    = gate_starts(flags_i.unrestr, block_w);
    assign h2_next    = harm2_ok_w ? flags_i.harm2 : '0;

    // Saturation supervisor
    dpdl_sat_sup #(
        .QUAL_CYCLES       (QUAL_CYCLES)
    ) u_sat_sup (
        .core_clk_i        (core_clk_i),
        .rst_i             (rst_i),
        .ce_i              (ce_i),
        .bias_i            (bias_i),
        .diff_below_base_i (diff_below_base_i),
        .desens_o          (desens_w)
    );

    // Start outputs, registered on each sample
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            restrained_start_o       <= '0;
            restrained_start_any_o   <= 1'b0;
            unrestrained_start_o     <= '0;
            unrestrained_start_any_o <= 1'b0;
        end else if (ce_i && sample_i) begin
            restrained_start_o       <= rs_next;
            restrained_start_any_o   <= |rs_next;
            unrestrained_start_o     <= us_next;
            unrestrained_start_any_o <= |us_next;
        end
    end

    // Harmonic restraint outputs
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            harm2_restraint_o          <= '0;
            harm2_restraint_any_o      <= 1'b0;
            fifth_harmonic_restraint_o <= 1'b0;
        end else if (ce_i && sample_i) begin
            harm2_restraint_o          <= h2_next;
            harm2_restraint_any_o      <= |h2_next;
            fifth_harmonic_restraint_o <= |flags_i.harm5;
        end
    end

    // Characteristic selection for the evaluator
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            desens_o        <= 1'b0;
            slopes_o.slope1 <= dpdl_pkg::NORM_SLOPE1_PCT;
            slopes_o.slope2 <= dpdl_pkg::NORM_SLOPE2_PCT;
        end else if (ce_i) begin
            desens_o        <= desens_w;
            slopes_o.slope1 <= desens_w ? dpdl_pkg::DESENS_SLOPE1_PCT : dpdl_pkg::NORM_SLOPE1_PCT;
            slopes_o.slope2 <= desens_w ? dpdl_pkg::DESENS_SLOPE2_PCT : dpdl_pkg::NORM_SLOPE2_PCT;
        end
    end

    // Measurements pass regardless of blocking
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            diff_meas_o <= '0;
            bias_meas_o <= '0;
        end else if (ce_i && sample_i) begin
            diff_meas_o <= diff_i;
            bias_meas_o <= bias_i;
        end
    end

    // Blocking clears every start on the next edge
    sequence blocked_sample_s;
        ce_i && sample_i && block_w;
    endsequence
    block_start_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        blocked_sample_s |=> restrained_start_o == '0 && unrestrained_start_o == '0
            && !restrained_start_any_o && !unrestrained_start_any_o)
        else $error("Start seen while blocked");
    phase_start_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        ce_i && sample_i |=> restrained_start_o
            == ($past(flags_i.restr) & {dpdl_pkg::NUM_PHASES{!$past(block_w)}}))
        else $error("Restrained phase start wrong");
    gen_start_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        ce_i && sample_i |=> restrained_start_any_o == |restrained_start_o)
        else $error("General restrained start wrong");
    unr_start_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        ce_i && sample_i |=> unrestrained_start_o
            == ($past(flags_i.unrestr) & {dpdl_pkg::NUM_PHASES{!$past(block_w)}}))
        else $error("Unrestrained phase start wrong");
    unr_gen_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        ce_i && sample_i |=> unrestrained_start_any_o == |unrestrained_start_o)
        else $error("General unrestrained start wrong");
    harm2_angle_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        ce_i && sample_i && !harm2_ok_w |=> harm2_restraint_o == '0 && !harm2_restraint_any_o)
        else $error("Second harmonic restraint without angle");
    harm5_any_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        ce_i && sample_i |=> fifth_harmonic_restraint_o == |$past(flags_i.harm5))
        else $error("Fifth harmonic restraint wrong");
    desens_slope_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        desens_o |-> slopes_o.slope1 == dpdl_pkg::DESENS_SLOPE1_PCT)
        else $error("Desensitised slope wrong");

    // A taken processing sample
    sequence sample_s;
        ce_i && sample_i;
    endsequence

    // A taken sample whose angle difference permits second harmonic restraint
    sequence open_angle_s;
        ce_i && sample_i && harm2_ok_w;
    endsequence

    // An edge at which the clock enable holds every register
    sequence frozen_s;
        !ce_i;
    endsequence

    // Each phase restraint follows its own flag once the angle allows it
    generate
        for (genvar p = 0; p < dpdl_pkg::NUM_PHASES; p++) begin : g_phase_chk
            harm2_phase_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
                open_angle_s |=> harm2_restraint_o[p] == $past(flags_i.harm2[p]))
                else $error("Phase second harmonic restraint wrong");
        end
    endgenerate

    // General second harmonic restraint is the OR of the phase restraints
    harm2_any_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        sample_s |=> harm2_restraint_any_o == |harm2_restraint_o)
        else $error("General second harmonic restraint wrong");

    // Measurements pass on every sample, blocked or not
    meas_pass_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        sample_s |=> diff_meas_o == $past(diff_i) && bias_meas_o == $past(bias_i))
        else $error("Measurement not passed");

    // Less sensitive mode reaches the evaluator with its slopes on the next edge
    desens_pair_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        ce_i && desens_w |=> desens_o && slopes_o.slope1 == dpdl_pkg::DESENS_SLOPE1_PCT
            && slopes_o.slope2 == dpdl_pkg::DESENS_SLOPE2_PCT)
        else $error("Less sensitive slopes not selected");

    // Normal mode restores the default slopes on the next edge
    normal_pair_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        ce_i && !desens_w |=> !desens_o && slopes_o.slope1 == dpdl_pkg::NORM_SLOPE1_PCT
            && slopes_o.slope2 == dpdl_pkg::NORM_SLOPE2_PCT)
        else $error("Normal slopes not restored");

    // A low clock enable holds phase restrained starts, general unrestrained start, phase and fifth harmonic restraints, mode, slopes and bias
    freeze_hold_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        frozen_s |=> $stable(restrained_start_o) && $stable(unrestrained_start_any_o)
            && $stable(harm2_restraint_o) && $stable(fifth_harmonic_restraint_o)
            && $stable(desens_o) && $stable(slopes_o) && $stable(bias_meas_o))
        else $error("Output moved while clock enable low");
endmodule // dpdl_top
`default_nettype wire

// ---- src/dpdl_pkg.sv ----
// Package of constants and carrier types for the differential protection decision logic
package dpdl_pkg;
    localparam int unsigned NUM_PHASES       = 3;
    localparam int unsigned MAG_W            = 16;   // Current magnitude width, unit = In/256
    localparam int unsigned ANG_W            = 9;    // Angle difference width in degrees
    localparam int unsigned CLK_MHZ          = 250;
    localparam int unsigned SAT_QUAL_TIME_US = 3000; // Entry qualification time, 3 ms
    localparam int unsigned SAT_QUAL_CYCLES  = SAT_QUAL_TIME_US * CLK_MHZ;
    localparam logic [MAG_W-1:0] BIAS_ENTER_LVL = 16'h0140; // 1.25 In
    localparam logic [MAG_W-1:0] BIAS_EXIT_LVL  = 16'h00cd; // 0.8 In (204.8 rounded up)
    localparam logic [ANG_W-1:0] ANGLE_MIN_DEG  = 9'h04b;   // 75 degrees
    localparam logic [7:0] NORM_SLOPE1_PCT  = 8'h14;        // Default 20 %
    localparam logic [7:0] NORM_SLOPE2_PCT  = 8'hc8;        // Default 200 %
    localparam logic [7:0] DESENS_SLOPE1_PCT = 8'h32;       // 50 %
    localparam logic [7:0] DESENS_SLOPE2_PCT = 8'hc8;       // 200 %

    // Per-phase flags from the characteristic evaluator and harmonic estimators
    typedef struct packed {
        logic [NUM_PHASES-1:0] restr;
        logic [NUM_PHASES-1:0] unrestr;
        logic [NUM_PHASES-1:0] harm2;
        logic [NUM_PHASES-1:0] harm5;
    } dpdl_flags_t;

    // Slopes handed back to the characteristic evaluator
    typedef struct packed {
        logic [7:0] slope1;
        logic [7:0] slope2;
    } dpdl_slopes_t;

    typedef enum logic [1:0] {
        DPDL_NORMAL  = 2'b00,
        DPDL_QUALIFY = 2'b01,
        DPDL_DESENS  = 2'b11
    } dpdl_mode_t;
endpackage

// ---- src/dpdl_sat_sup.sv ----
// Adaptive-characteristic supervisor for CT saturation during external faults
`timescale 1ns/100ps
`default_nettype none
module dpdl_sat_sup #(
    parameter int unsigned QUAL_CYCLES = dpdl_pkg::SAT_QUAL_CYCLES
) (
    // Clock, reset, enable
    input  wire logic                                          core_clk_i,
    input  wire logic                                          rst_i,
    input  wire logic                                          ce_i,
    // Measurements
    input  wire logic [dpdl_pkg::NUM_PHASES*dpdl_pkg::MAG_W-1:0] bias_i,
    input  wire logic [dpdl_pkg::NUM_PHASES-1:0]               diff_below_base_i,
    // Mode
    output logic                                               desens_o
);
    dpdl_pkg::dpdl_mode_t mode_reg;
    logic [31:0]          cnt_reg;
    logic                 enter_cond;
    logic                 exit_cond;

    // Entry: any phase with high bias and small differential; exit: bias low everywhere
    always_comb begin
        enter_cond = 1'b0;
        exit_cond  = 1'b1;
        for (int p = 0; p < dpdl_pkg::NUM_PHASES; p++) begin
            if (bias_i[p*dpdl_pkg::MAG_W +: dpdl_pkg::MAG_W] > dpdl_pkg::BIAS_ENTER_LVL
                && diff_below_base_i[p])
                enter_cond = 1'b1;
            if (bias_i[p*dpdl_pkg::MAG_W +: dpdl_pkg::MAG_W] >= dpdl_pkg::BIAS_EXIT_LVL)
                exit_cond = 1'b0;
        end
    end

    // Mode state machine with qualification counter
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            mode_reg <= dpdl_pkg::DPDL_NORMAL;
            cnt_reg  <= 32'h0000_0000;
        end else if (ce_i) begin
            case (mode_reg)
                dpdl_pkg::DPDL_NORMAL: begin
                    cnt_reg <= 32'h0000_0000;
                    if (enter_cond) begin
                        mode_reg <= dpdl_pkg::DPDL_QUALIFY;
                        cnt_reg  <= 32'h0000_0001;
                    end
                end
                dpdl_pkg::DPDL_QUALIFY: begin
                    if (!enter_cond) begin
                        mode_reg <= dpdl_pkg::DPDL_NORMAL;
                        cnt_reg  <= 32'h0000_0000;
                    end else if (cnt_reg >= QUAL_CYCLES) begin
                        mode_reg <= dpdl_pkg::DPDL_DESENS;
                    end else begin
                        cnt_reg <= cnt_reg + 32'h0000_0001;
                    end
                end
                dpdl_pkg::DPDL_DESENS: begin
                    cnt_reg <= 32'h0000_0000;
                    if (exit_cond)
                        mode_reg <= dpdl_pkg::DPDL_NORMAL;
                end
                default: begin
                    mode_reg <= dpdl_pkg::DPDL_NORMAL;
                    cnt_reg  <= 32'h0000_0000;
                end
            endcase
        end
    end

    assign desens_o = (mode_reg == dpdl_pkg::DPDL_DESENS);

    // An interrupted qualification falls back to normal and starts over
    qual_time_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        ce_i && mode_reg == dpdl_pkg::DPDL_QUALIFY && !enter_cond |=> mode_reg == dpdl_pkg::DPDL_NORMAL)
        else $error("Qualification not restarted");
    exit_low_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        ce_i && desens_o && exit_cond |=> !desens_o)
        else $error("Desensitised mode not left on low bias");
    // In normal mode the entry condition always opens a qualification
    enter_qual_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        ce_i && mode_reg == dpdl_pkg::DPDL_NORMAL && enter_cond |=> mode_reg == dpdl_pkg::DPDL_QUALIFY)
        else $error("Qualification not started");
    // Desensitised mode never starts before the qualification time
    early_desens_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        ce_i && mode_reg == dpdl_pkg::DPDL_QUALIFY && cnt_reg < QUAL_CYCLES |=> mode_reg != dpdl_pkg::DPDL_DESENS)
        else $error("Desensitised before qualification time");
endmodule // dpdl_sat_sup
`default_nettype wire

// ---- testbench/dpdl_char_model.sv ----
// Behavioural characteristic evaluator and harmonic estimator facing the decision logic
`timescale 1ns/100ps
`default_nettype none
module dpdl_char_model #(
    parameter logic [15:0] BASE_LVL = 16'h0033,
    parameter logic [15:0] HIGH_LVL = 16'h0800
) (
    // Measurements and harmonic detections
    input  wire logic [47:0]           diff_i,
    input  wire logic [2:0]            h2_i,
    input  wire logic [2:0]            h5_i,
    // Flags toward the decision logic
    output var dpdl_pkg::dpdl_flags_t  flags_o,
    output logic [2:0]                 below_o
);
    // Per-phase threshold decisions from the same sample
    always_comb begin
        flags_o.harm2 = h2_i;
        flags_o.harm5 = h5_i;
        for (int p = 0; p < 3; p++) begin
            flags_o.restr[p]   = diff_i[16*p +: 16] > BASE_LVL;
            flags_o.unrestr[p] = diff_i[16*p +: 16] > HIGH_LVL;
            below_o[p]         = diff_i[16*p +: 16] < BASE_LVL;
        end
    end
endmodule // dpdl_char_model
`default_nettype wire

// ---- testbench/diff_protection_decision_logic_test.sv ----
// Self-checking bench of the differential protection decision logic
`timescale 1ns/100ps
`default_nettype none
module diff_protection_decision_logic_test;
    localparam logic [15:0] BASE = 16'h0033;
    localparam logic [15:0] HIGH = 16'h0800;
    logic clk = 0, rst = 1, smp_i = 0, en = 1, dis = 0, ce = 1, desens;
    logic [47:0] diff = '0, bias = '0, dmo, bmo;
    logic [2:0] h2 = '0, h5 = '0, below, rs, us, h2o;
    logic [8:0] ang = '0;
    logic ra, ua, h2a, h5a;
    dpdl_pkg::dpdl_flags_t fl;
    dpdl_pkg::dpdl_slopes_t slp;
    logic [108:0] q[$];
    logic [108:0] last_exp = '0;
    int err_total = 0, cmp_count = 0, cyc = 0;
    logic [15:0] lv[3] = '{16'h0010, 16'h0040, 16'h0900};

    always #2 clk = ~clk;
    dpdl_char_model #(.BASE_LVL(BASE), .HIGH_LVL(HIGH)) i_dpdl_char_model (
        .diff_i(diff), .h2_i(h2), .h5_i(h5), .flags_o(fl), .below_o(below));
    dpdl_top #(.QUAL_CYCLES(20)) i_dpdl_top (
        .core_clk_i(clk), .rst_i(rst), .ce_i(ce), .sample_i(smp_i),
        .func_enable_i(en), .user_disable_input_i(dis), .flags_i(fl),
        .bias_i(bias), .diff_i(diff), .diff_below_base_i(below), .angle_diff_i(ang),
        .restrained_start_o(rs), .restrained_start_any_o(ra), .unrestrained_start_o(us),
        .unrestrained_start_any_o(ua), .harm2_restraint_o(h2o), .harm2_restraint_any_o(h2a),
        .fifth_harmonic_restraint_o(h5a), .desens_o(desens), .slopes_o(slp),
        .diff_meas_o(dmo), .bias_meas_o(bmo));

    task automatic chk(input string nm, input logic [108:0] e, input logic [108:0] g);
        cmp_count++;
        if (g !== e) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // One sample: expectation noted, inputs applied, strobe left high without a gap for a back-to-back follower
    task automatic sample(input logic gap);
        logic blk;
        logic [2:0] r, u, g2;
        blk = dis | ~en;
        for (int p = 0; p < 3; p++) begin
            r[p] = diff[16*p +: 16] > BASE;
            u[p] = diff[16*p +: 16] > HIGH;
        end
        r = blk ? 3'h0 : r;
        u = blk ? 3'h0 : u;
        g2 = (ang >= dpdl_pkg::ANGLE_MIN_DEG) ? h2 : 3'h0;
        // A sample under a low clock enable must leave every output as it stood
        if (ce) begin
            last_exp = {r, |r, u, |u, g2, |g2, |h5, bias, diff};
        end
        q.push_back(last_exp);
        smp_i = 1;
        @(negedge clk);
        if (gap) begin
            smp_i = 0;
            @(negedge clk);
        end
    endtask

    // Result watcher: the cycle after each taken sample
    always @(posedge clk) begin
        if (smp_i === 1'b1 && rst === 1'b0) begin
            @(negedge clk);
            chk("outputs", q.pop_front(), {rs, ra, us, ua, h2o, h2a, h5a, bmo, dmo});
        end
    end

    // Hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            err_total++;
            tally_and_finish();
        end
    end

    initial begin
        void'($urandom(66917));
        repeat (2) @(negedge clk);
        chk("reset slopes", {dpdl_pkg::NORM_SLOPE1_PCT, dpdl_pkg::NORM_SLOPE2_PCT}, slp);
        rst = 0;
        // Random starts, harmonics, block and angle, samples partly back to back
        for (int n = 0; n < 60; n++) begin
            for (int p = 0; p < 3; p++) diff[16*p +: 16] = lv[$urandom_range(2)];
            bias = 48'({$urandom, $urandom}) & 48'h00ff_00ff_00ff;
            {h2, h5} = 6'($urandom);
            dis = ($urandom_range(3) == 0);
            ce = ($urandom_range(3) != 0);
            en = ($urandom_range(3) != 0);
            ang = 9'($urandom_range(70, 80));
            sample($urandom_range(1));
        end
        smp_i = 0;
        ce = 1;
        repeat (2) @(negedge clk);
        chk("queue left", 0, q.size());
        $display("test random done");
        // Reset in mid-run clears every sampled output and restores the default slopes
        rst = 1;
        repeat (2) @(negedge clk);
        rst = 0;
        chk("reset outputs", 0, {rs, ra, us, ua, h2o, h2a, h5a, bmo, dmo});
        chk("mid reset slopes", {dpdl_pkg::NORM_SLOPE1_PCT, dpdl_pkg::NORM_SLOPE2_PCT}, slp);
        $display("test reset done");
        // Large bias with large differential must not desensitise
        bias = {16'h0, 16'h0141, 16'h0};
        diff = {3{16'h0040}};
        repeat (40) @(negedge clk);
        chk("desens big diff", 0, desens);
        // Interrupted qualification restarts
        diff = '0;
        repeat (15) @(negedge clk);
        bias[31:16] = 16'h0140;
        @(negedge clk);
        bias[31:16] = 16'h0141;
        repeat (18) @(negedge clk);
        chk("desens early", 0, desens);
        for (int i = 0; i < 30 && desens !== 1'b1; i++) @(negedge clk);
        chk("desens set", 1, desens);
        chk("desens slopes", {dpdl_pkg::DESENS_SLOPE1_PCT, dpdl_pkg::DESENS_SLOPE2_PCT}, slp);
        // Exit only strictly below the lower level
        bias[31:16] = 16'h00cd;
        repeat (5) @(negedge clk);
        chk("desens hold", 1, desens);
        bias[31:16] = 16'h00cc;
        repeat (3) @(negedge clk);
        chk("desens clear", 0, desens);
        chk("normal slopes", {dpdl_pkg::NORM_SLOPE1_PCT, dpdl_pkg::NORM_SLOPE2_PCT}, slp);
        $display("test desens done");
        tally_and_finish();
    end
endmodule // diff_protection_decision_logic_test
`default_nettype wire
